// *** hw/rlcr_pkg.sv ***
package rlcr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_OVERRIDE   = 8'h08;
    localparam logic [7:0] ADDR_SPARE_A    = 8'h09;
    localparam logic [7:0] ADDR_MONITOR    = 8'h0a;
    localparam logic [7:0] ADDR_SPARE_B    = 8'h0b;
    localparam logic [7:0] ADDR_SPARE_C    = 8'h0c;
    localparam logic [7:0] ADDR_SPARE_D    = 8'h0d;
    localparam logic [7:0] ADDR_IDLE_TERM  = 8'h0e;
    localparam logic [7:0] ADDR_EQUALIZER  = 8'h0f;
    localparam logic [7:0] ADDR_SWING      = 8'h10;
    localparam logic [7:0] ADDR_EMPHASIS   = 8'h11;
    localparam logic [7:0] ADDR_THRESHOLD  = 8'h12;
    localparam logic [7:0] ADDR_SPARE_E    = 8'h13;
    localparam logic [7:0] ADDR_SPARE_F    = 8'h14;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_SPARE_B     = 8'h70;
    localparam logic [7:0] RST_EQUALIZER   = 8'h2f;
    localparam logic [7:0] RST_SWING       = 8'had;
    localparam logic [4:0] RST_EMPH_RW     = 5'h02;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OVR_THRESH_BIT    = 6;
    localparam int OVR_IDLE_BIT      = 4;
    localparam int OVR_TERM_BIT      = 3;
    localparam int OVR_RATE_BIT      = 2;
    localparam int IDLE_AUTO_BIT     = 5;
    localparam int IDLE_MUTE_BIT     = 4;
    localparam int TERM_HI           = 3;
    localparam int TERM_LO           = 2;
    localparam int SWING_SHORT_BIT   = 7;
    localparam int SWING_RATE_BIT    = 6;
    localparam int SWING_CODE_HI     = 2;
    localparam int EMPH_FOUND_BIT    = 7;
    localparam int EMPH_SPEED_HI     = 6;
    localparam int EMPH_SPEED_LO     = 5;
    localparam int EMPH_RW_HI        = 4;
    localparam int EMPH_CODE_HI      = 2;
    localparam int TH_ASSERT_HI      = 3;
    localparam int TH_ASSERT_LO      = 2;
    localparam int TH_DEASSERT_HI    = 1;
    localparam int LANE_B0_BIT       = 0;

    // ----------------------------------------------------------------
    // termination modes
    // ----------------------------------------------------------------
    localparam logic [1:0] TERM_HIZ      = 2'h0;
    localparam logic [1:0] TERM_PROBE_50 = 2'h1;
    localparam logic [1:0] TERM_PROBE_ON = 2'h2;
    localparam logic [1:0] TERM_FIXED_50 = 2'h3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLOCK_KHZ          = 100000;
    localparam int PROBE_INTERVAL_MS  = 12;
    localparam int PROBE_INTERVAL_CYC = PROBE_INTERVAL_MS * CLOCK_KHZ;
    localparam logic [5:0] PROBE_ATTEMPT_LIMIT = 6'h32;

    typedef enum logic [1:0] {
        RLCR_PROBE_IDLE,
        RLCR_PROBE_WAIT,
        RLCR_PROBE_FOUND,
        RLCR_PROBE_GIVEUP
    } rlcr_probe_t;

endpackage

// *** hw/rlcr_regs.sv ***
`timescale 1ns/1ps
module rlcr_regs #(
    parameter int PROBE_INTERVAL = rlcr_pkg::PROBE_INTERVAL_CYC
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       cfg_load_valid,
    input  wire logic [7:0] cfg_load_addr,
    input  wire logic [7:0] cfg_load_data,
    input  wire logic       rate_pin_float,
    input  wire logic       rate_pin_gen12,
    input  wire logic       far_termination_probe_pin,
    input  wire logic [1:0] squelch_threshold_pin,
    input  wire logic [7:0] lane_idle_detect,
    input  wire logic       far_receiver_sense,
    input  wire logic [1:0] speed_sense,
    output logic            lane_b0_output_mute,
    output logic            lane_b0_input_term_50,
    output logic            far_termination_probe,
    output logic      [7:0] equalizer_level,
    output logic      [2:0] swing_level,
    output logic            short_protect_en,
    output logic            rate_gen12,
    output logic      [2:0] emphasis_level,
    output logic      [1:0] squelch_assert_code,
    output logic      [1:0] squelch_deassert_code
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_W = 16;

    logic [SYNC_W-1:0] sync_a_reg;
    logic [SYNC_W-1:0] sync_b_reg;
    logic              rate_float_s;
    logic              rate_gen12_s;
    logic              term_pin_s;
    logic [1:0]        thresh_pin_s;
    logic [7:0]        idle_s;
    logic              far_found_s;
    logic [1:0]        speed_s;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
        end
        else
        begin
            sync_a_reg <= {rate_pin_float, rate_pin_gen12, far_termination_probe_pin,
                           squelch_threshold_pin, lane_idle_detect, far_receiver_sense,
                           speed_sense};
            sync_b_reg <= sync_a_reg;
        end
    end

    assign rate_float_s = sync_b_reg[15];
    assign rate_gen12_s = sync_b_reg[14];
    assign term_pin_s   = sync_b_reg[13];
    assign thresh_pin_s = sync_b_reg[12:11];
    assign idle_s       = sync_b_reg[10:3];
    assign far_found_s  = sync_b_reg[2];
    assign speed_s      = sync_b_reg[1:0];

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0] override_reg;
    logic [7:0] spare_a_reg;
    logic [7:0] spare_b_reg;
    logic [7:0] spare_c_reg;
    logic [7:0] spare_d_reg;
    logic [7:0] idle_term_reg;
    logic [7:0] equalizer_reg;
    logic [7:0] swing_reg;
    logic [4:0] emph_rw_reg;
    logic [7:0] threshold_reg;
    logic [7:0] spare_e_reg;
    logic [7:0] spare_f_reg;
    logic       found_reg;

    // host access wins; configuration memory shares the write path
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    assign wr_en   = reg_wr | cfg_load_valid;
    assign wr_addr = reg_wr ? reg_addr : cfg_load_addr;
    assign wr_data = reg_wr ? reg_wdata : cfg_load_data;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            override_reg  <= rlcr_pkg::RST_ZERO;
            spare_a_reg   <= rlcr_pkg::RST_ZERO;
            spare_b_reg   <= rlcr_pkg::RST_SPARE_B;
            spare_c_reg   <= rlcr_pkg::RST_ZERO;
            spare_d_reg   <= rlcr_pkg::RST_ZERO;
            idle_term_reg <= rlcr_pkg::RST_ZERO;
            equalizer_reg <= rlcr_pkg::RST_EQUALIZER;
            swing_reg     <= rlcr_pkg::RST_SWING;
            emph_rw_reg   <= rlcr_pkg::RST_EMPH_RW;
            threshold_reg <= rlcr_pkg::RST_ZERO;
            spare_e_reg   <= rlcr_pkg::RST_ZERO;
            spare_f_reg   <= rlcr_pkg::RST_ZERO;
        end
        else if (wr_en)
        begin
            // monitor and status bits have no storage, so writes fall away
            if (hit(wr_addr, rlcr_pkg::ADDR_OVERRIDE))
                override_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_A))
                spare_a_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_B))
                spare_b_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_C))
                spare_c_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_D))
                spare_d_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_IDLE_TERM))
                idle_term_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_EQUALIZER))
                equalizer_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SWING))
                swing_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_EMPHASIS))
                emph_rw_reg <= wr_data[rlcr_pkg::EMPH_RW_HI:0];
            if (hit(wr_addr, rlcr_pkg::ADDR_THRESHOLD))
                threshold_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_E))
                spare_e_reg <= wr_data;
            if (hit(wr_addr, rlcr_pkg::ADDR_SPARE_F))
                spare_f_reg <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb
    begin
        case (reg_addr)
            rlcr_pkg::ADDR_OVERRIDE:  rd_mux = override_reg;
            rlcr_pkg::ADDR_SPARE_A:   rd_mux = spare_a_reg;
            rlcr_pkg::ADDR_MONITOR:   rd_mux = idle_s;
            rlcr_pkg::ADDR_SPARE_B:   rd_mux = spare_b_reg;
            rlcr_pkg::ADDR_SPARE_C:   rd_mux = spare_c_reg;
            rlcr_pkg::ADDR_SPARE_D:   rd_mux = spare_d_reg;
            rlcr_pkg::ADDR_IDLE_TERM: rd_mux = idle_term_reg;
            rlcr_pkg::ADDR_EQUALIZER: rd_mux = equalizer_reg;
            rlcr_pkg::ADDR_SWING:     rd_mux = swing_reg;
            rlcr_pkg::ADDR_EMPHASIS:  rd_mux = {found_reg, speed_s, emph_rw_reg};
            rlcr_pkg::ADDR_THRESHOLD: rd_mux = threshold_reg;
            rlcr_pkg::ADDR_SPARE_E:   rd_mux = spare_e_reg;
            rlcr_pkg::ADDR_SPARE_F:   rd_mux = spare_f_reg;
            default:                  rd_mux = rlcr_pkg::RST_ZERO;
        endcase
    end

    // reads only sample, nothing is cleared by them
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= rlcr_pkg::RST_ZERO;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // ----------------------------------------------------------------
    // termination mode selection
    // ----------------------------------------------------------------
    logic [1:0] term_mode;

    // pin high asks for open-ended probing, pin low leaves input hi-Z
    always_comb
    begin
        if (override_reg[rlcr_pkg::OVR_TERM_BIT])
            term_mode = idle_term_reg[rlcr_pkg::TERM_HI:rlcr_pkg::TERM_LO];
        else if (term_pin_s)
            term_mode = rlcr_pkg::TERM_PROBE_ON;
        else
            term_mode = rlcr_pkg::TERM_HIZ;
    end

    // ----------------------------------------------------------------
    // far-end receiver probing
    // ----------------------------------------------------------------
    rlcr_pkg::rlcr_probe_t probe_state_reg;
    logic [31:0]           interval_cnt_reg;
    logic [5:0]            attempt_cnt_reg;
    logic [1:0]            last_mode_reg;
    logic                  probe_pulse_reg;
    logic                  mode_changed;
    logic                  interval_done;
    logic                  probing;

    assign mode_changed  = (term_mode != last_mode_reg);
    assign interval_done = (interval_cnt_reg == 32'(PROBE_INTERVAL - 1));
    assign probing       = (term_mode == rlcr_pkg::TERM_PROBE_50) ||
                           (term_mode == rlcr_pkg::TERM_PROBE_ON);

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            last_mode_reg <= rlcr_pkg::TERM_HIZ;
        else
            last_mode_reg <= term_mode;
    end

    // a change of mode restarts the whole search from scratch
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            probe_state_reg  <= rlcr_pkg::RLCR_PROBE_IDLE;
            interval_cnt_reg <= '0;
            attempt_cnt_reg  <= '0;
            probe_pulse_reg  <= 1'b0;
        end
        else
        begin
            probe_pulse_reg <= 1'b0;
            if (mode_changed || !probing)
            begin
                probe_state_reg  <= probing ? rlcr_pkg::RLCR_PROBE_WAIT
                                            : rlcr_pkg::RLCR_PROBE_IDLE;
                interval_cnt_reg <= '0;
                attempt_cnt_reg  <= '0;
            end
            else
            begin
                case (probe_state_reg)
                    rlcr_pkg::RLCR_PROBE_IDLE:
                        probe_state_reg <= rlcr_pkg::RLCR_PROBE_WAIT;
                    rlcr_pkg::RLCR_PROBE_WAIT:
                    begin
                        if (far_found_s)
                            probe_state_reg <= rlcr_pkg::RLCR_PROBE_FOUND;
                        else if (interval_done)
                        begin
                            interval_cnt_reg <= '0;
                            probe_pulse_reg  <= 1'b1;
                            attempt_cnt_reg  <= attempt_cnt_reg + 6'h01;
                            if (term_mode == rlcr_pkg::TERM_PROBE_50 &&
                                attempt_cnt_reg == rlcr_pkg::PROBE_ATTEMPT_LIMIT - 6'h01)
                                probe_state_reg <= rlcr_pkg::RLCR_PROBE_GIVEUP;
                        end
                        else
                            interval_cnt_reg <= interval_cnt_reg + 32'h1;
                    end
                    rlcr_pkg::RLCR_PROBE_FOUND:
                        probe_state_reg <= rlcr_pkg::RLCR_PROBE_FOUND;
                    rlcr_pkg::RLCR_PROBE_GIVEUP:
                        // a late answer still counts, but no more probes go out
                        if (far_found_s)
                            probe_state_reg <= rlcr_pkg::RLCR_PROBE_FOUND;
                    default:
                        probe_state_reg <= rlcr_pkg::RLCR_PROBE_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            found_reg <= 1'b0;
        else if (term_mode == rlcr_pkg::TERM_FIXED_50)
            found_reg <= far_found_s;
        else
            found_reg <= probing && !mode_changed &&
                         probe_state_reg == rlcr_pkg::RLCR_PROBE_FOUND;
    end

    // ----------------------------------------------------------------
    // lane controls
    // ----------------------------------------------------------------
    logic idle_by_regs;

    assign idle_by_regs = override_reg[rlcr_pkg::OVR_IDLE_BIT] &&
                          idle_term_reg[rlcr_pkg::IDLE_AUTO_BIT];

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lane_b0_output_mute   <= 1'b0;
            lane_b0_input_term_50 <= 1'b0;
            far_termination_probe <= 1'b0;
        end
        else
        begin
            if (idle_by_regs)
                lane_b0_output_mute <= idle_term_reg[rlcr_pkg::IDLE_MUTE_BIT];
            else
                lane_b0_output_mute <= idle_s[rlcr_pkg::LANE_B0_BIT];
            case (term_mode)
                rlcr_pkg::TERM_HIZ:      lane_b0_input_term_50 <= 1'b0;
                rlcr_pkg::TERM_FIXED_50: lane_b0_input_term_50 <= 1'b1;
                default:
                    lane_b0_input_term_50 <= probing && !mode_changed &&
                        probe_state_reg == rlcr_pkg::RLCR_PROBE_FOUND;
            endcase
            far_termination_probe <= probe_pulse_reg;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            equalizer_level       <= rlcr_pkg::RST_EQUALIZER;
            swing_level           <= rlcr_pkg::RST_SWING[rlcr_pkg::SWING_CODE_HI:0];
            short_protect_en      <= rlcr_pkg::RST_SWING[rlcr_pkg::SWING_SHORT_BIT];
            rate_gen12            <= 1'b0;
            emphasis_level        <= rlcr_pkg::RST_EMPH_RW[rlcr_pkg::EMPH_CODE_HI:0];
            squelch_assert_code   <= 2'h0;
            squelch_deassert_code <= 2'h0;
        end
        else
        begin
            equalizer_level  <= equalizer_reg;
            swing_level      <= swing_reg[rlcr_pkg::SWING_CODE_HI:0];
            short_protect_en <= swing_reg[rlcr_pkg::SWING_SHORT_BIT];
            if (override_reg[rlcr_pkg::OVR_RATE_BIT])
                rate_gen12 <= swing_reg[rlcr_pkg::SWING_RATE_BIT];
            else
                rate_gen12 <= rate_gen12_s;
            emphasis_level <= emph_rw_reg[rlcr_pkg::EMPH_CODE_HI:0];
            if (override_reg[rlcr_pkg::OVR_THRESH_BIT])
            begin
                squelch_assert_code <=
                    threshold_reg[rlcr_pkg::TH_ASSERT_HI:rlcr_pkg::TH_ASSERT_LO];
                squelch_deassert_code <=
                    threshold_reg[rlcr_pkg::TH_DEASSERT_HI:0];
            end
            else
            begin
                squelch_assert_code   <= thresh_pin_s;
                squelch_deassert_code <= thresh_pin_s;
            end
        end
    end

    // the float flag is synchronised but drives nothing and cannot be read, the monitor shows idle_s only
    logic unused_float;
    assign unused_float = rate_float_s;

endmodule

// *** sim/rlcr_regs_chk.sv ***
`timescale 1ns/1ps
module rlcr_regs_chk (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] equalizer_level,
    input wire logic [2:0] swing_level,
    input wire logic       short_protect_en,
    input wire logic [2:0] emphasis_level,
    input wire logic       far_termination_probe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_reset_values: assert property (
        $rose(nrst) |-> equalizer_level == 8'h2f && swing_level == 3'h5
            && emphasis_level == 3'h2 && short_protect_en
    ) else $error("wrong settings after reset");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)
    ) else $error("read data moved without a read");
    a_eq_write: assert property (
        reg_wr && reg_addr == rlcr_pkg::ADDR_EQUALIZER
            |-> ##2 equalizer_level == $past(reg_wdata, 2)
    ) else $error("equalizer level not taken from write");
    a_swing_write: assert property (
        reg_wr && reg_addr == rlcr_pkg::ADDR_SWING |-> ##2 swing_level == $past(reg_wdata[2:0], 2)
            && short_protect_en == $past(reg_wdata[7], 2)
    ) else $error("swing fields not taken from write");
    a_emph_write: assert property (
        reg_wr && reg_addr == rlcr_pkg::ADDR_EMPHASIS
            |-> ##2 emphasis_level == $past(reg_wdata[2:0], 2)
    ) else $error("emphasis code not taken from write");
    a_eq_readback: assert property (
        reg_rd && !reg_wr && reg_addr == rlcr_pkg::ADDR_EQUALIZER |=> reg_rdata == equalizer_level
    ) else $error("equalizer readback differs from level");
    a_unmapped_zero: assert property (
        reg_rd && (reg_addr < rlcr_pkg::ADDR_OVERRIDE || reg_addr > rlcr_pkg::ADDR_SPARE_F)
            |=> reg_rdata == 8'h00
    ) else $error("unmapped read not zero");
    a_probe_pulse: assert property (
        far_termination_probe |=> !far_termination_probe [*6]
    ) else $error("probe pulses too close");
endmodule

// *** sim/rlcr_loader.sv ***
`timescale 1ns/1ps
module rlcr_loader (
    input  wire logic       clock,
    input  wire logic       go,
    output logic            cfg_load_valid,
    output logic      [7:0] cfg_load_addr,
    output logic      [7:0] cfg_load_data
);
    // ----
    // image, address then data, same layout as host writes
    // ----
    logic [15:0] image [3] = '{16'h0b70, 16'h10ad, 16'h0fc3};

    initial
    begin
        cfg_load_valid = 1'b0;
        {cfg_load_addr, cfg_load_data} = 16'h0000;
    end

    always @(posedge go)
    begin
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            #1;
            cfg_load_valid = 1'b1;
            {cfg_load_addr, cfg_load_data} = image[i];
        end
        @(posedge clock);
        #1;
        cfg_load_valid = 1'b0;
        // released bus shows no stale value
        {cfg_load_addr, cfg_load_data} = ~image[2];
    end
endmodule

// *** sim/test_repeater_lane_config_registers.sv ***
`timescale 1ns/1ps
module test_repeater_lane_config_registers;
    logic       clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, cfg_load_addr, cfg_load_data;
    logic       rate_pin_float = 1'b1, rate_pin_gen12 = 1'b0, far_termination_probe_pin = 1'b0;
    logic [1:0] squelch_threshold_pin = 2'h2, speed_sense = 2'h0;
    logic [7:0] lane_idle_detect = 8'h00, equalizer_level;
    logic       far_receiver_sense = 1'b0, cfg_load_valid, lane_b0_output_mute;
    logic       lane_b0_input_term_50, far_termination_probe, short_protect_en, rate_gen12;
    logic [2:0] swing_level, emphasis_level;
    logic [1:0] squelch_assert_code, squelch_deassert_code;
    int         bad_count = 0, n_checks = 0, n_probe = 0;

    rlcr_regs #(.PROBE_INTERVAL(8)) rlcr_regs_inst (
        .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .cfg_load_valid, .cfg_load_addr, .cfg_load_data, .rate_pin_float,
        .rate_pin_gen12, .far_termination_probe_pin, .squelch_threshold_pin,
        .lane_idle_detect, .far_receiver_sense, .speed_sense, .lane_b0_output_mute,
        .lane_b0_input_term_50, .far_termination_probe, .equalizer_level, .swing_level,
        .short_protect_en, .rate_gen12, .emphasis_level, .squelch_assert_code,
        .squelch_deassert_code
    );
    rlcr_loader rlcr_loader_inst (.clock, .go, .cfg_load_valid, .cfg_load_addr, .cfg_load_data);

    always #5 clock = ~clock;
    always @(posedge clock) if (far_termination_probe === 1'b1) n_probe++;

    // ----
    // helpers
    // ----
    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idle(1);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        idle(1);
        reg_wr = 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        idle(1);
        {reg_addr, reg_rd} = {a, 1'b1};
        idle(1);
        reg_rd = 1'b0;
        chk(reg_rdata, e);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_reset;
        logic [7:0] tab [13] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h2f,
                                 8'had, 8'h02, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 13; i++)
            rc(8'h08 + 8'(i), tab[i]);
        chk({swing_level, emphasis_level, short_protect_en, rate_gen12}, 8'haa);
    endtask
    task automatic t_access;
        wr(8'h0f, 8'h5a);
        rc(8'h0f, 8'h5a);
        wr(8'h0a, 8'hff);
        rc(8'h0a, 8'h00);
        wr(8'h11, 8'he7);
        rc(8'h11, 8'h07);
        wr(8'h30, 8'h55);
        rc(8'h30, 8'h00);
        wr(8'h10, 8'h2a);
        idle(1);
        chk({4'h0, short_protect_en, swing_level}, 8'h02);
    endtask
    task automatic t_monitor;
        lane_idle_detect = 8'h81;
        idle(4);
        rc(8'h0a, 8'h81);
        lane_idle_detect = 8'h7e;
        idle(4);
        rc(8'h0a, 8'h7e);
    endtask
    task automatic t_control;
        wr(8'h08, 8'h5c);
        wr(8'h0e, 8'h30);
        idle(2);
        chk({7'h0, lane_b0_output_mute}, 8'h01);
        wr(8'h0e, 8'h20);
        idle(2);
        chk({7'h0, lane_b0_output_mute}, 8'h00);
        wr(8'h0e, 8'h10);
        idle(2);
        chk({7'h0, lane_b0_output_mute}, 8'h00);
        wr(8'h10, 8'h6d);
        wr(8'h12, 8'h0d);
        idle(2);
        chk({3'h0, rate_gen12, squelch_assert_code,
             squelch_deassert_code}, 8'h1d);
        wr(8'h08, 8'h00);
        idle(5);
        chk({3'h0, rate_gen12, squelch_assert_code, squelch_deassert_code}, 8'h0a);
    endtask
    task automatic t_term;
        {far_termination_probe_pin, speed_sense} = 3'b101;
        wr(8'h08, 8'h08);
        wr(8'h0e, 8'h0c);
        idle(2);
        chk({7'h0, lane_b0_input_term_50}, 8'h01);
        wr(8'h0e, 8'h00);
        idle(30);
        n_probe = 0;
        idle(30);
        chk({7'h0, lane_b0_input_term_50}, 8'h00);
        chk(8'(n_probe), 8'h00);
        wr(8'h0e, 8'h04);
        idle(1000);
        chk(8'(n_probe), 8'h32);
        wr(8'h11, 8'h02);
        wr(8'h0e, 8'h08);
        n_probe = 0;
        idle(100);
        chk(8'(n_probe > 5), 8'h01);
        far_receiver_sense = 1'b1;
        for (int i = 0; i < 20 && lane_b0_input_term_50 !== 1'b1; i++)
            idle(1);
        chk({7'h0, lane_b0_input_term_50}, 8'h01);
        rc(8'h11, 8'ha2);
        n_probe = 0;
        idle(50);
        chk(8'(n_probe), 8'h00);
    endtask
    task automatic t_load;
        go = 1'b1;
        idle(6);
        go = 1'b0;
        rc(8'h0f, 8'hc3);
        rc(8'h0b, 8'h70);
        chk({swing_level, short_protect_en, 4'h0}, 8'hb0);
    endtask

    initial
    begin
        idle(4);
        nrst = 1'b1;
        t_reset;
        t_access;
        t_monitor;
        t_control;
        t_term;
        t_load;
        give_verdict;
    end
    initial
    begin
        #500000;
        bad_count++;
        give_verdict;
    end
endmodule

bind rlcr_regs rlcr_regs_chk rlcr_regs_chk_inst (
    .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .equalizer_level,
    .swing_level, .short_protect_en, .emphasis_level, .far_termination_probe
);
